// >>> shared/csiu_pkg.sv
package csiu_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses, word aligned)
  // ------------------------------------------------------------
  localparam logic [3:0] REG_FLAGS   = 4'h0;
  localparam logic [3:0] REG_PENDING = 4'h4;
  localparam logic [3:0] REG_STATE   = 4'h8;

  // ------------------------------------------------------------
  // Flag positions in core_condition_flags
  // ------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_H = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_G = 4;
  localparam int FLAG_R = 5;
  localparam logic [7:0] FLAGS_RESET   = 8'h00;
  localparam logic [7:0] FLAGS_SW_MASK = 8'h1f;

  // ------------------------------------------------------------
  // Interrupt sources, index = priority - 1
  // ------------------------------------------------------------
  localparam int SRC_TRAP   = 0;
  localparam int SRC_TIMER1 = 1;
  localparam int SRC_TIMER0 = 2;
  localparam int SRC_WAKEUP = 3;
  localparam int NUM_SRC    = 4;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int INSTR_CYCLE_NS  = 1000;
  localparam int CLKS_PER_INSTR  = INSTR_CYCLE_NS / CLK_PERIOD_NS;
  localparam int ENTRY_CYCLES    = 5;
  localparam int VECTOR_STEP     = 2;

  // ------------------------------------------------------------
  // Addressing
  // ------------------------------------------------------------
  localparam int PC_W       = 11;
  localparam int REL_MIN    = -31;
  localparam int REL_MAX    = 32;

  typedef enum logic [2:0] {
    AM_INDEXED,
    AM_INDIRECT,
    AM_DIRECT,
    AM_IMMEDIATE,
    AM_ABSOLUTE,
    AM_RELATIVE
  } csiu_amode_t;

endpackage

// >>> shared/csiu_stack_if.sv
`timescale 1ns/1ps
`default_nettype none
interface csiu_stack_if #(parameter int W = 11);
  logic         push;
  logic         pop;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic         empty;
  logic         full;

  modport ctrl (output push, output pop, output wdata, input rdata, input empty, input full);
  modport mem  (input push, input pop, input wdata, output rdata, output empty, output full);
endinterface
`default_nettype wire

// >>> rtl/csiu_stack.sv
`timescale 1ns/1ps
`default_nettype none
module csiu_stack #(
  parameter int W     = 11,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Stack port
  csiu_stack_if.mem st
);

  localparam int SPW = $clog2(DEPTH + 1);
  localparam int AW  = $clog2(DEPTH);

  logic [W-1:0]   mem_r [DEPTH];
  logic [SPW-1:0] sp_r;
  logic [W-1:0]   rdata_r;

  // ------------------------------------------------------------
  // Pointer
  // ------------------------------------------------------------
  // Overflow push and underflow pop are dropped, not wrapped
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      sp_r <= '0;
    else if (st.push && !st.full)
      sp_r <= sp_r + SPW'(1);
    else if (st.pop && !st.empty)
      sp_r <= sp_r - SPW'(1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (st.push && !st.full)
      mem_r[sp_r[AW-1:0]] <= st.wdata;
  end

  // ------------------------------------------------------------
  // Registered read, valid one clock after pop
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_r <= '0;
    else if (st.pop && !st.empty)
      rdata_r <= mem_r[AW'(sp_r - SPW'(1))];
  end

  assign st.rdata = rdata_r;
  assign st.empty = (sp_r == '0);
  assign st.full  = (sp_r == SPW'(DEPTH));

endmodule
`default_nettype wire

// >>> rtl/csiu_core.sv
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module csiu_core #(
  parameter int          XW          = 16,
  parameter int          STACK_DEPTH = 8,
  parameter int          CLK_DIV     = csiu_pkg::CLKS_PER_INSTR,
  parameter logic [10:0] VEC_WAKEUP  = 11'h7f6,
  parameter logic [10:0] VEC_TIMER0  = 11'h7f8,
  parameter logic [10:0] VEC_TIMER1  = 11'h7fa,
  parameter logic [10:0] VEC_TRAP    = 11'h7fc
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Instruction stream events
  input  wire logic        instr_done,
  input  wire logic [10:0] pc_in,
  input  wire logic        alu_update,
  input  wire logic [3:0]  alu_flag_sel,
  input  wire logic [7:0]  alu_result,
  input  wire logic        alu_carry,
  input  wire logic        alu_half,
  input  wire logic        rotate_op,
  input  wire logic        rotate_right,
  input  wire logic [7:0]  rotate_data,
  input  wire logic        load_carry_op,
  input  wire logic        load_carry_value,
  input  wire logic        invert_carry_op,
  input  wire logic        mask_set_op,
  input  wire logic        call_op,
  input  wire logic        software_trap_op,
  input  wire logic        interrupt_return_op,
  input  wire logic        subroutine_return_op,
  // Interrupt sources
  input  wire logic        wakeup_edge_request,
  input  wire logic        timer_zero_request,
  input  wire logic        timer_one_request,
  input  wire logic [2:0]  source_clear,
  input  wire logic        nvm_write_busy,
  // Operand addressing
  input  wire logic [2:0]  addr_mode,
  input  wire logic [XW-1:0] index_ptr,
  input  wire logic [7:0]  operand_lo,
  input  wire logic [7:0]  operand_hi,
  output logic [10:0]      eff_addr,
  output logic [7:0]       operand_value,
  // Core side results
  output logic [7:0]       core_condition_flags,
  output logic [7:0]       rotate_result,
  output logic             pc_load,
  output logic [10:0]      pc_load_value,
  output logic             int_entry_busy,
  output logic [1:0]       int_source
);

  typedef enum logic [1:0] { CS_IDLE, CS_ENTRY, CS_RETURN } csiu_state_t;

  localparam int DIVW = $clog2(CLK_DIV + 1);

  csiu_state_t                   state_r;
  logic [7:0]                    flags_r;
  logic [csiu_pkg::NUM_SRC-1:0]  pend_r;
  logic [csiu_pkg::NUM_SRC-1:0]  eligible;
  logic [csiu_pkg::NUM_SRC-1:0]  serviced;
  logic [1:0]                    win;
  logic                          any_win;
  logic [DIVW-1:0]               div_r;
  logic                          instr_ce;
  logic [2:0]                    step_r;
  logic [1:0]                    src_r;
  logic [10:0]                   vec_r;
  logic                          interrupt_return_op_r;
  logic                          entry_done;
  logic                          rd_ack_r;
  logic                          bus_wr_flags;
  logic [10:0]                   rel_tgt;
  logic [7:0]                    rel_disp;

  csiu_stack_if #(.W(csiu_pkg::PC_W)) stk ();

  csiu_stack #(
    .W     (csiu_pkg::PC_W),
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .st      (stk)
  );

  // ------------------------------------------------------------
  // Instruction-cycle enable
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      div_r <= '0;
    else if (state_r != CS_ENTRY || instr_ce)
      div_r <= '0;
    else
      div_r <= div_r + DIVW'(1);
  end

  assign instr_ce = (div_r == DIVW'(CLK_DIV - 1));

  // ------------------------------------------------------------
  // Pending latches
  // ------------------------------------------------------------
  // Set beats clear so a request in the clearing cycle survives
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      pend_r <= '0;
    else
    begin
      pend_r <= pend_r & ~serviced;
      pend_r[csiu_pkg::SRC_WAKEUP] <= (pend_r[csiu_pkg::SRC_WAKEUP] & ~source_clear[2]
                                       & ~serviced[csiu_pkg::SRC_WAKEUP]) | wakeup_edge_request;
      pend_r[csiu_pkg::SRC_TIMER0] <= (pend_r[csiu_pkg::SRC_TIMER0] & ~source_clear[1]
                                       & ~serviced[csiu_pkg::SRC_TIMER0]) | timer_zero_request;
      pend_r[csiu_pkg::SRC_TIMER1] <= (pend_r[csiu_pkg::SRC_TIMER1] & ~source_clear[0]
                                       & ~serviced[csiu_pkg::SRC_TIMER1]) | timer_one_request;
      pend_r[csiu_pkg::SRC_TRAP]   <= (pend_r[csiu_pkg::SRC_TRAP] & ~serviced[csiu_pkg::SRC_TRAP])
                                       | software_trap_op;
    end
  end

  // ------------------------------------------------------------
  // Arbitration
  // ------------------------------------------------------------
  always_comb
  begin
    eligible = pend_r & {{(csiu_pkg::NUM_SRC-1){flags_r[csiu_pkg::FLAG_G]}}, 1'b1};
    win      = 2'd0;
    any_win  = 1'b0;
    for (int i = 0; i < csiu_pkg::NUM_SRC; i++)
    begin
      if (eligible[i])
      begin
        win     = 2'(i);
        any_win = 1'b1;
      end
    end
  end

  assign entry_done = (state_r == CS_ENTRY) && instr_ce && (step_r == 3'(csiu_pkg::ENTRY_CYCLES - 1));

  always_comb
  begin
    serviced = '0;
    if (entry_done)
      serviced[src_r] = 1'b1;
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= CS_IDLE;
      step_r  <= '0;
      src_r   <= '0;
      vec_r   <= '0;
      interrupt_return_op_r  <= 1'b0;
    end
    else
    begin
      case (state_r)
        CS_IDLE:
        begin
          step_r <= '0;
          if (instr_done && any_win)
          begin
            state_r <= CS_ENTRY;
            src_r   <= win;
          end
          else if (interrupt_return_op || subroutine_return_op)
          begin
            state_r <= CS_RETURN;
            interrupt_return_op_r  <= interrupt_return_op;
          end
        end
        CS_ENTRY:
        begin
          if (instr_ce)
          begin
            step_r <= step_r + 3'd1;
            if (step_r == 3'(csiu_pkg::VECTOR_STEP))
            begin
              case (src_r)
                2'(csiu_pkg::SRC_WAKEUP): vec_r <= VEC_WAKEUP;
                2'(csiu_pkg::SRC_TIMER0): vec_r <= VEC_TIMER0;
                2'(csiu_pkg::SRC_TIMER1): vec_r <= VEC_TIMER1;
                default:                  vec_r <= VEC_TRAP;
              endcase
            end
            if (entry_done)
              state_r <= CS_IDLE;
          end
        end
        CS_RETURN:
          state_r <= CS_IDLE;
        default:
          state_r <= CS_IDLE;
      endcase
    end
  end

  // Stack traffic: entry pushes at recognition, calls push too
  assign stk.push  = (state_r == CS_IDLE) && ((instr_done && any_win) || call_op);
  assign stk.wdata = pc_in;
  assign stk.pop   = (state_r == CS_IDLE) && !(instr_done && any_win)
                     && (interrupt_return_op || subroutine_return_op);

  // ------------------------------------------------------------
  // PC redirect
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_load       <= 1'b0;
      pc_load_value <= '0;
    end
    else
    begin
      pc_load <= entry_done || (state_r == CS_RETURN);
      if (entry_done)
        pc_load_value <= vec_r;
      else if (state_r == CS_RETURN)
        pc_load_value <= stk.rdata;
    end
  end

  // ------------------------------------------------------------
  // Condition flags
  // ------------------------------------------------------------
  assign bus_wr_flags = avs_write && avs_byteenable[0] && (avs_address == csiu_pkg::REG_FLAGS);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      flags_r <= csiu_pkg::FLAGS_RESET;
    else
    begin
      if (bus_wr_flags)
        flags_r[4:0] <= avs_writedata[4:0] & csiu_pkg::FLAGS_SW_MASK[4:0];
      if (alu_update)
      begin
        if (alu_flag_sel[csiu_pkg::FLAG_C])
          flags_r[csiu_pkg::FLAG_C] <= alu_carry;
        if (alu_flag_sel[csiu_pkg::FLAG_H])
          flags_r[csiu_pkg::FLAG_H] <= alu_half;
        if (alu_flag_sel[csiu_pkg::FLAG_Z])
          flags_r[csiu_pkg::FLAG_Z] <= (alu_result == 8'h00);
        if (alu_flag_sel[csiu_pkg::FLAG_N])
          flags_r[csiu_pkg::FLAG_N] <= alu_result[7];
      end
      if (rotate_op)
        flags_r[csiu_pkg::FLAG_C] <= rotate_right ? rotate_data[0] : rotate_data[7];
      else if (load_carry_op)
        flags_r[csiu_pkg::FLAG_C] <= load_carry_value;
      else if (invert_carry_op)
        flags_r[csiu_pkg::FLAG_C] <= ~flags_r[csiu_pkg::FLAG_C];
      if (mask_set_op)
        flags_r[csiu_pkg::FLAG_G] <= 1'b1;
      if (state_r == CS_RETURN && interrupt_return_op_r)
        flags_r[csiu_pkg::FLAG_G] <= 1'b1;
      if (entry_done)
        flags_r[csiu_pkg::FLAG_G] <= 1'b0;
      flags_r[csiu_pkg::FLAG_R] <= nvm_write_busy;
      flags_r[7:6] <= 2'b00;
    end
  end

  // Rotate passes through carry for multi-word shifts
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rotate_result <= '0;
    else if (rotate_op)
      rotate_result <= rotate_right ? {flags_r[csiu_pkg::FLAG_C], rotate_data[7:1]}
                                    : {rotate_data[6:0], flags_r[csiu_pkg::FLAG_C]};
  end

  // ------------------------------------------------------------
  // Effective address generation
  // ------------------------------------------------------------
  // Displacement saturated to the reachable window
  always_comb
  begin
    if ($signed(operand_lo) < $signed(8'(csiu_pkg::REL_MIN)))
      rel_disp = 8'(csiu_pkg::REL_MIN);
    else if ($signed(operand_lo) > $signed(8'(csiu_pkg::REL_MAX)))
      rel_disp = 8'(csiu_pkg::REL_MAX);
    else
      rel_disp = operand_lo;
    rel_tgt = pc_in + {{3{rel_disp[7]}}, rel_disp};
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      eff_addr      <= '0;
      operand_value <= '0;
    end
    else
    begin
      operand_value <= 8'h00;
      case (csiu_pkg::csiu_amode_t'(addr_mode))
        csiu_pkg::AM_INDEXED:
          eff_addr <= index_ptr[10:0] + {3'b000, operand_lo};
        csiu_pkg::AM_INDIRECT:
          eff_addr <= index_ptr[10:0];
        csiu_pkg::AM_DIRECT:
          eff_addr <= {3'b000, operand_lo};
        csiu_pkg::AM_IMMEDIATE:
        begin
          eff_addr      <= '0;
          operand_value <= operand_lo;
        end
        csiu_pkg::AM_ABSOLUTE:
          eff_addr <= {operand_hi[2:0], operand_lo};
        csiu_pkg::AM_RELATIVE:
          eff_addr <= rel_tgt;
        default:
          eff_addr <= '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Avalon-MM slave
  // ------------------------------------------------------------
  // Reads take one wait state so read data come from a flop
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_ack_r     <= 1'b0;
      avs_readdata <= '0;
    end
    else
    begin
      rd_ack_r <= avs_read && !rd_ack_r;
      if (avs_read && !rd_ack_r)
      begin
        case (avs_address)
          csiu_pkg::REG_FLAGS:   avs_readdata <= {24'h000000, flags_r};
          csiu_pkg::REG_PENDING: avs_readdata <= {28'h0000000, pend_r};
          csiu_pkg::REG_STATE:   avs_readdata <= {12'h000, pc_load_value, 1'b0,
                                                  stk.full, stk.empty, int_entry_busy, src_r, step_r};
          default:               avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  assign avs_waitrequest      = avs_read && !rd_ack_r;
  assign core_condition_flags = flags_r;
  assign int_entry_busy       = (state_r == CS_ENTRY);
  assign int_source           = src_r;

endmodule
`default_nettype wire

// >>> sim/csiu_core_props.sv
`timescale 1ns/1ps
`default_nettype none
module csiu_core_props #(
  parameter int CLK_DIV = 2
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // Core events
  input wire logic        avs_write,
  input wire logic        instr_done,
  input wire logic        alu_update,
  input wire logic [3:0]  alu_flag_sel,
  input wire logic [7:0]  alu_result,
  input wire logic        load_carry_op,
  input wire logic        load_carry_value,
  input wire logic        mask_set_op,
  input wire logic        interrupt_return_op,
  input wire logic        subroutine_return_op,
  input wire logic        nvm_write_busy,
  input wire logic [2:0]  addr_mode,
  input wire logic [15:0] index_ptr,
  input wire logic [7:0]  operand_lo,
  // Results
  input wire logic [10:0] eff_addr,
  input wire logic [7:0]  core_condition_flags,
  input wire logic        pc_load,
  input wire logic        int_entry_busy
);
  // ----------
  // Entry length
  // ----------
  // Entry spans hundreds of clocks, so a counter replaces a repetition
  int unsigned busy_cnt_r;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      busy_cnt_r <= 0;
    else
      busy_cnt_r <= int_entry_busy ? busy_cnt_r + 1 : 0;
  end
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  top_bits_zero_a: assert property (core_condition_flags[7:6] == 2'b00)
    else $error("flag bits 7:6 set");
  zero_flag_a: assert property (alu_update && alu_flag_sel[2] |=>
    core_condition_flags[2] == ($past(alu_result) == 8'h00)) else $error("zero flag wrong");
  neg_flag_a: assert property (alu_update && alu_flag_sel[3] |=>
    core_condition_flags[3] == $past(alu_result[7])) else $error("negative flag wrong");
  carry_load_a: assert property (load_carry_op |=>
    core_condition_flags[0] == $past(load_carry_value)) else $error("carry load wrong");
  mask_set_a: assert property ($rose(core_condition_flags[4]) |-> $past(mask_set_op) ||
    $past(avs_write) || $past(interrupt_return_op, 2)) else $error("mask set without cause");
  entry_start_a: assert property ($rose(int_entry_busy) |-> $past(instr_done))
    else $error("entry not at boundary");
  entry_end_a: assert property ($fell(int_entry_busy) |-> pc_load &&
    !core_condition_flags[4] && busy_cnt_r == csiu_pkg::ENTRY_CYCLES * CLK_DIV)
    else $error("entry length or mask wrong");
  sub_return_a: assert property (subroutine_return_op && !int_entry_busy |-> ##2
    (pc_load && core_condition_flags[4] == $past(core_condition_flags[4], 2)))
    else $error("subroutine return wrong");
  int_return_a: assert property (interrupt_return_op && !int_entry_busy |-> ##2
    (pc_load && core_condition_flags[4])) else $error("interrupt return wrong");
  nvm_flag_a: assert property ($past(reset_n) |->
    core_condition_flags[5] == $past(nvm_write_busy)) else $error("write flag wrong");
  indexed_addr_a: assert property (addr_mode == 3'h0 |=> eff_addr ==
    11'($past(index_ptr)) + 11'($past(operand_lo))) else $error("indexed address wrong");
endmodule
`default_nettype wire

// >>> sim/csiu_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module csiu_src_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Bench command: [2] wakeup, [1] timer0, [0] timer1
  input  wire logic [2:0] fire,
  // Requests
  output logic            wakeup_edge_request,
  output logic            timer_zero_request,
  output logic            timer_one_request
);
  // Requests last only while commanded; the core must latch them
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      {wakeup_edge_request, timer_zero_request, timer_one_request} <= 3'h0;
    else
      {wakeup_edge_request, timer_zero_request, timer_one_request} <= fire;
  end
endmodule
`default_nettype wire

// >>> sim/core_status_interrupt_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module core_status_interrupt_unit_test;
  // ----------
  // Signals
  // ----------
  localparam int CLK_DIV = 2;
  localparam int P_DONE = 0, P_MASK = 1, P_CALL = 2, P_TRAP = 3, P_IRET = 4;
  localparam int P_SRET = 5, P_LOADC = 6, P_FLIP = 7, P_ROT = 8, P_ALU = 9;
  logic sys_clk, reset_n, avs_read, avs_write, avs_waitrequest, instr_done;
  logic [3:0] avs_address, avs_byteenable, alu_flag_sel;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic alu_update, alu_carry, alu_half, rotate_op, rotate_right, load_carry_op;
  logic load_carry_value, invert_carry_op, mask_set_op, call_op, software_trap_op;
  logic interrupt_return_op, subroutine_return_op, nvm_write_busy, pc_load, int_entry_busy;
  logic wakeup_edge_request, timer_zero_request, timer_one_request, lg;
  logic [2:0] source_clear, addr_mode, fire;
  logic [10:0] pc_in, eff_addr, pc_load_value, lv;
  logic [7:0] alu_result, rotate_data, operand_lo, operand_hi, operand_value;
  logic [7:0] core_condition_flags, rotate_result;
  logic [15:0] index_ptr;
  logic [1:0] int_source, ls;
  int num_errors, compares;

  csiu_core #(.CLK_DIV(CLK_DIV)) u_csiu_core (.*);
  csiu_src_model u_csiu_src_model (.*);

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ----------
  // Helpers
  // ----------
  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("Counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Request held until waitrequest is sampled low; a clock passes before the next
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (int i = 0; i < 20; i++)
    begin
      tick();
      if (avs_waitrequest === 1'b0)
      begin
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        tick();
        return;
      end
    end
    num_errors++;
    print_verdict();
  endtask
  task automatic pulse(int k);
    for (int v = 1; v >= 0; v--)
    begin
      case (k)
        P_DONE: instr_done <= v[0];
        P_MASK: mask_set_op <= v[0];
        P_CALL: call_op <= v[0];
        P_TRAP: software_trap_op <= v[0];
        P_IRET: interrupt_return_op <= v[0];
        P_SRET: subroutine_return_op <= v[0];
        P_LOADC: load_carry_op <= v[0];
        P_FLIP: invert_carry_op <= v[0];
        P_ROT: rotate_op <= v[0];
        default: alu_update <= v[0];
      endcase
      tick();
    end
  endtask
  task automatic wait_load;
    for (int i = 0; i < 60; i++)
    begin
      if (pc_load === 1'b1)
      begin
        lv = pc_load_value;
        ls = int_source;
        lg = core_condition_flags[4];
        return;
      end
      tick();
    end
    num_errors++;
    print_verdict();
  endtask
  task automatic alu(logic [3:0] s, logic [7:0] r, logic c, logic h);
    alu_flag_sel <= s;
    alu_result <= r;
    alu_carry <= c;
    alu_half <= h;
    pulse(P_ALU);
  endtask
  task automatic am(csiu_pkg::csiu_amode_t m, logic [15:0] p, logic [7:0] lo, logic [7:0] hi);
    addr_mode <= m;
    index_ptr <= p;
    operand_lo <= lo;
    operand_hi <= hi;
    tick(2);
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_reset;
    chk("flags", 32'h0, 32'(core_condition_flags));
    bus(1'b1, 4'hc, 32'hff);
    bus(1'b0, 4'hc, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, csiu_pkg::REG_FLAGS, 32'h0);
    chk("flags reg", 32'h0, rd);
    $display("t_reset done");
  endtask
  task automatic t_flags;
    alu(4'hf, 8'h80, 1'b1, 1'b1);
    chk("chzn", 32'hb, 32'(core_condition_flags[3:0]));
    alu(4'hf, 8'h00, 1'b0, 1'b0);
    chk("zero", 32'h4, 32'(core_condition_flags[3:0]));
    alu(4'hc, 8'h7f, 1'b1, 1'b1);
    chk("zn only", 32'h0, 32'(core_condition_flags[3:0]));
    load_carry_value <= 1'b1;
    pulse(P_LOADC);
    chk("carry load", 32'h1, 32'(core_condition_flags[3:0]));
    pulse(P_FLIP);
    chk("carry flip", 32'h0, 32'(core_condition_flags[3:0]));
    rotate_data <= 8'h81;
    pulse(P_ROT);
    chk("rotate", 32'h02, 32'(rotate_result));
    chk("rot carry", 32'h1, 32'(core_condition_flags[0]));
    rotate_right <= 1'b1;
    rotate_data <= 8'h02;
    pulse(P_ROT);
    chk("ror", 32'h102, 32'({rotate_result, core_condition_flags[0]}));
    $display("t_flags done");
  endtask
  task automatic t_bus_g;
    nvm_write_busy <= 1'b1;
    bus(1'b1, csiu_pkg::REG_FLAGS, 32'hff);
    bus(1'b0, csiu_pkg::REG_FLAGS, 32'h0);
    chk("flags rw", 32'h3f, rd);
    reset_n <= 1'b0;
    tick(2);
    reset_n <= 1'b1;
    tick(3);
    chk("g reset", 32'h0, 32'(core_condition_flags[4]));
    nvm_write_busy <= 1'b0;
    tick(2);
    $display("t_bus_g done");
  endtask
  task automatic t_mask;
    fire <= 3'b011;
    tick();
    fire <= 3'b000;
    tick(2);
    pulse(P_DONE);
    tick(3);
    chk("no entry", 32'h0, 32'(int_entry_busy));
    source_clear <= 3'b001;
    tick();
    source_clear <= 3'b000;
    bus(1'b0, csiu_pkg::REG_PENDING, 32'h0);
    chk("pending", 32'h4, rd);
    pulse(P_MASK);
    pulse(P_DONE);
    wait_load();
    chk("vector", 32'h7f8, 32'(lv));
    chk("source", 32'h2, 32'(ls));
    chk("g entry", 32'h0, 32'(lg));
    $display("t_mask done");
  endtask
  task automatic t_prio;
    logic [10:0] vec [4] = '{11'h7f6, 11'h7f8, 11'h7fa, 11'h7fc};
    fire <= 3'b111;
    pulse(P_TRAP);
    fire <= 3'b000;
    // Last pass has the mask clear, so only the trap may enter
    for (int i = 0; i < 4; i++)
    begin
      if (i < 3)
        pulse(P_MASK);
      pulse(P_DONE);
      wait_load();
      tick();
      chk("vector", 32'(vec[i]), 32'(lv));
      chk("source", 32'(3 - i), 32'(ls));
    end
    $display("t_prio done");
  endtask
  task automatic t_returns;
    pc_in <= 11'h123;
    pulse(P_MASK);
    pulse(P_CALL);
    pulse(P_SRET);
    wait_load();
    chk("sret pc", 32'h123, 32'(lv));
    chk("sret g", 32'h1, 32'(lg));
    pc_in <= 11'h155;
    pulse(P_TRAP);
    pulse(P_DONE);
    wait_load();
    chk("trap g", 32'h0, 32'(lg));
    tick();
    pulse(P_IRET);
    wait_load();
    chk("iret pc", 32'h155, 32'(lv));
    chk("iret g", 32'h1, 32'(lg));
    $display("t_returns done");
  endtask
  task automatic t_addr;
    am(csiu_pkg::AM_INDEXED, 16'hfffe, 8'h03, 8'h00);
    chk("indexed", 32'h001, 32'(eff_addr));
    am(csiu_pkg::AM_INDIRECT, 16'h0345, 8'h00, 8'h00);
    chk("indirect", 32'h345, 32'(eff_addr));
    am(csiu_pkg::AM_DIRECT, 16'h0000, 8'ha5, 8'h00);
    chk("direct", 32'h0a5, 32'(eff_addr));
    am(csiu_pkg::AM_IMMEDIATE, 16'h0000, 8'h5a, 8'h00);
    chk("immediate", 32'h5a, 32'(operand_value));
    am(csiu_pkg::AM_ABSOLUTE, 16'h0000, 8'h34, 8'hfd);
    chk("absolute", 32'h534, 32'(eff_addr));
    pc_in <= 11'h100;
    am(csiu_pkg::AM_RELATIVE, 16'h0000, 8'h7f, 8'h00);
    chk("rel max", 32'h120, 32'(eff_addr));
    am(csiu_pkg::AM_RELATIVE, 16'h0000, 8'h80, 8'h00);
    chk("rel min", 32'h0e1, 32'(eff_addr));
    $display("t_addr done");
  endtask

  initial
  begin
    {reset_n, avs_read, avs_write, instr_done, alu_update, alu_carry, alu_half} = '0;
    {rotate_op, rotate_right, load_carry_op, load_carry_value, invert_carry_op} = '0;
    {mask_set_op, call_op, software_trap_op, interrupt_return_op, subroutine_return_op} = '0;
    {nvm_write_busy, avs_address, alu_flag_sel, avs_writedata, source_clear} = '0;
    {addr_mode, fire, pc_in, alu_result, rotate_data, operand_lo, operand_hi, index_ptr} = '0;
    avs_byteenable = 4'hf;
    num_errors = 0;
    compares = 0;
    tick(5);
    reset_n <= 1'b1;
    tick();
    t_reset();
    t_flags();
    t_bus_g();
    t_mask();
    t_prio();
    t_returns();
    t_addr();
    print_verdict();
  end
endmodule

bind csiu_core csiu_core_props #(.CLK_DIV(CLK_DIV)) u_csiu_core_props (.*);
`default_nettype wire
